/* hdl/iod_pkg.sv */
package iod_pkg;

   // size of the decoded map
   localparam int          IOD_NREG        = 37;
   // data-space address of I/O location zero
   localparam logic [7:0]  IOD_DATA_OFFSET = 8'h20;
   // first I/O address the short instructions cannot encode (64 locations)
   localparam logic [7:0]  IOD_SHORT_LIMIT = 8'h40;
   // last I/O address reachable by the single-bit instructions
   localparam logic [7:0]  IOD_BIT_LAST    = 8'h1f;
   // first data address of the extended area, load/store only
   localparam logic [7:0]  IOD_EXT_BASE    = 8'h60;
   // value of every stored bit after reset
   localparam logic [7:0]  IOD_RESET_VALUE = 8'h00;

   // access kinds issued by the core
   typedef enum logic [2:0] {
      IOD_OP_IO_READ    = 3'h0,
      IOD_OP_IO_WRITE   = 3'h1,
      IOD_OP_SET_BIT    = 3'h2,
      IOD_OP_CLEAR_BIT  = 3'h3,
      IOD_OP_SKIP_SET   = 3'h4,
      IOD_OP_SKIP_CLEAR = 3'h5,
      IOD_OP_LOAD       = 3'h6,
      IOD_OP_STORE      = 3'h7
   } iod_op_t;

   // one map entry: data address, implemented bits, write-one-to-clear bits
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] mask;
      logic [7:0] w1c;
   } iod_entry_t;

   localparam iod_entry_t IOD_MAP [IOD_NREG] = '{
      '{8'h35, 8'h0f, 8'h0f},  // timer0_flags
      '{8'h36, 8'h0f, 8'h0f},  // timer1_flags
      '{8'h3b, 8'h03, 8'h03},  // pin_change_flags
      '{8'h3c, 8'h01, 8'h01},  // ext_int_flags
      '{8'h3d, 8'h01, 8'h00},  // ext_int_mask
      '{8'h3e, 8'hff, 8'h00},  // general_purpose_0
      '{8'h3f, 8'h3f, 8'h00},  // eeprom_ctrl
      '{8'h40, 8'hff, 8'h00},  // eeprom_data
      '{8'h41, 8'hff, 8'h00},  // eeprom_addr_low
      '{8'h42, 8'h03, 8'h00},  // eeprom_addr_high
      '{8'h43, 8'h81, 8'h00},  // general_timer_ctrl
      '{8'h44, 8'hf1, 8'h00},  // timer0_ctrl_a
      '{8'h45, 8'h07, 8'h00},  // timer0_ctrl_b
      '{8'h46, 8'hff, 8'h00},  // timer0_count_low
      '{8'h47, 8'hff, 8'h00},  // timer0_count_high
      '{8'h48, 8'hff, 8'h00},  // timer0_compare_a
      '{8'h49, 8'hff, 8'h00},  // timer0_compare_b
      '{8'h4a, 8'hff, 8'h00},  // general_purpose_1
      '{8'h4b, 8'hff, 8'h00},  // general_purpose_2
      '{8'h4c, 8'hff, 8'h00},  // serial_periph_control
      '{8'h4d, 8'hc1, 8'h00},  // serial_periph_status
      '{8'h4e, 8'hff, 8'h00},  // serial_periph_data
      '{8'h4f, 8'h03, 8'h00},  // timer0_ctrl_c
      '{8'h51, 8'hff, 8'h00},  // onchip_debug_data
      '{8'h53, 8'h0f, 8'h00},  // sleep_mode_ctl
      '{8'h54, 8'h1f, 8'h00},  // mcu_reset_cause
      '{8'h55, 8'h33, 8'h00},  // mcu_control
      '{8'h57, 8'h3f, 8'h00},  // self_program_ctl
      '{8'h5d, 8'hff, 8'h00},  // stack_ptr_low
      '{8'h5e, 8'hff, 8'h00},  // stack_ptr_high
      '{8'h5f, 8'hff, 8'h00},  // status_flags
      '{8'h60, 8'hff, 8'h80},  // watchdog_ctl_status
      '{8'h61, 8'h83, 8'h00},  // clock_prescale
      '{8'h62, 8'hdf, 8'h80},  // wakeup_timer_ctl_status
      '{8'h63, 8'h07, 8'h00},  // wd_clear_ctrl
      '{8'h64, 8'h0f, 8'h00},  // power_reduction_0
      '{8'h66, 8'hff, 8'h00}   // slow_osc_cal_a
   };

   // entries the top level wires to its own ports
   localparam int IOD_IDX_TIMER0_FLAGS = 0;
   localparam int IOD_IDX_TIMER1_FLAGS = 1;
   localparam int IOD_IDX_PIN_CHANGE   = 2;
   localparam int IOD_IDX_EXT_INT_FLAG = 3;
   localparam int IOD_IDX_EXT_INT_MASK = 4;
   localparam int IOD_IDX_STACK_LOW    = 28;
   localparam int IOD_IDX_STACK_HIGH   = 29;
   localparam int IOD_IDX_STATUS       = 30;
   localparam int IOD_IDX_WATCHDOG     = 31;
   localparam int IOD_IDX_WAKEUP       = 33;
   // event flag position inside the watchdog and wakeup registers
   localparam int IOD_WD_FLAG_BIT      = 7;
   localparam int IOD_WU_FLAG_BIT      = 7;

endpackage

/* hdl/iod_decode.sv */
`timescale 1ns/1ps

module iod_decode (
   input  wire iod_pkg::iod_op_t          op,
   input  wire logic [7:0]                addr,
   output logic [iod_pkg::IOD_NREG-1:0]   sel,
   output logic                           hit,
   output logic                           refused
);

   logic [7:0] data_addr;

   // turn every access kind into one data-space address, or refuse it
   always_comb begin
      data_addr = addr;
      refused   = 1'b0;
      case (op)
         iod_pkg::IOD_OP_IO_READ,
         iod_pkg::IOD_OP_IO_WRITE: begin
            data_addr = addr + iod_pkg::IOD_DATA_OFFSET;
            refused   = (addr >= iod_pkg::IOD_SHORT_LIMIT);
         end
         iod_pkg::IOD_OP_SET_BIT,
         iod_pkg::IOD_OP_CLEAR_BIT,
         iod_pkg::IOD_OP_SKIP_SET,
         iod_pkg::IOD_OP_SKIP_CLEAR: begin
            data_addr = addr + iod_pkg::IOD_DATA_OFFSET;
            refused   = (addr > iod_pkg::IOD_BIT_LAST);
         end
         iod_pkg::IOD_OP_LOAD,
         iod_pkg::IOD_OP_STORE: begin
            // below the offset lies the core's own register file, not ours
            refused   = (addr < iod_pkg::IOD_DATA_OFFSET);
         end
         default: begin
            refused   = 1'b1;
         end
      endcase
   end

   // one comparator per entry; addresses are unique so at most one fires
   for (genvar i = 0; i < iod_pkg::IOD_NREG; i++) begin : g_match
      assign sel[i] = !refused && (data_addr == iod_pkg::IOD_MAP[i].addr);
   end

   assign hit = |sel;

endmodule // iod_decode

/* hdl/iod_reg_cell.sv */
`timescale 1ns/1ps

module iod_reg_cell #(
   parameter logic [7:0] MASK = 8'hff,
   parameter logic [7:0] W1C  = 8'h00
) (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] hw_set,
   output logic [7:0]      value
);

   typedef struct packed {
      logic [7:0] value;
   } iod_cell_state_t;

   iod_cell_state_t q;
   iod_cell_state_t next_q;
   logic [7:0]      kept;

   // plain bits load, flag bits clear on one, hardware set wins over the clear
   always_comb begin
      next_q = q;
      kept   = q.value;
      if (wr) begin
         kept = (wdata & MASK & ~W1C)
              | (q.value & W1C & ~wdata);
      end
      next_q.value = kept | (hw_set & W1C);
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q.value <= iod_pkg::IOD_RESET_VALUE;
      end else begin
         q <= next_q;
      end
   end

   assign value = q.value;

endmodule // iod_reg_cell

/* hdl/iod_top.sv */
`timescale 1ns/1ps

// What this block does
// - set/clear-bit instructions act on I/O 0x00..0x1f only; refused above.
// - skip instructions test one chosen bit of a bit-accessible register.
// - writing one clears a flag bit; writing zero leaves it.
// - set/clear-bit rewrites the whole register, so set flags other than the bit a clear-bit targets get cleared.
// - short I/O read/write reach only the first 64 I/O addresses.
// - data-space address minus hex 20 gives the I/O address.
// - extended area from data 0x60 reachable only by load and store.

module iod_top (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              acc_req,
   input  wire iod_pkg::iod_op_t  acc_op,
   input  wire logic [7:0]        acc_addr,
   input  wire logic [7:0]        acc_wdata,
   input  wire logic [2:0]        acc_bit,
   input  wire logic [3:0]        evt_timer0,
   input  wire logic [3:0]        evt_timer1,
   input  wire logic [1:0]        evt_pin_change,
   input  wire logic              evt_ext_int,
   input  wire logic              evt_watchdog,
   input  wire logic              evt_wakeup,
   output logic                   rsp_valid,
   output logic [7:0]             rsp_rdata,
   output logic                   rsp_skip,
   output logic                   rsp_hit,
   output logic                   rsp_refused,
   output logic [7:0]             status_flags,
   output logic [15:0]            stack_ptr,
   output logic                   ext_int_mask,
   output logic                   flags_pending
);

   localparam int N = iod_pkg::IOD_NREG;

   // registered answer to the core
   typedef struct packed {
      logic       valid;
      logic [7:0] rdata;
      logic       skip;
      logic       hit;
      logic       refused;
   } iod_top_state_t;

   iod_top_state_t       q;
   iod_top_state_t       next_q;

   logic [N-1:0]         sel;
   logic                 hit;
   logic                 refused;
   logic [N-1:0][7:0]    value;
   logic [N-1:0][7:0]    rd_part;
   logic [N-1:0][7:0]    hw_set;
   logic [N-1:0]         wr_en;
   logic [7:0]           cur;
   logic [7:0]           bit_mask;
   logic [7:0]           wr_data;
   logic [7:0]           pend_or;
   logic                 is_read;
   logic                 is_store;
   logic                 is_bit_op;
   logic                 is_skip;
   logic                 cur_bit;

   // address windows and register select
   iod_decode u_decode (
      .op      (acc_op),
      .addr    (acc_addr),
      .sel     (sel),
      .hit     (hit),
      .refused (refused)
   );

   // classify the access kind
   always_comb begin
      is_read   = 1'b0;
      is_store  = 1'b0;
      is_bit_op = 1'b0;
      is_skip   = 1'b0;
      case (acc_op)
         iod_pkg::IOD_OP_IO_READ,
         iod_pkg::IOD_OP_LOAD: begin
            is_read = 1'b1;
         end
         iod_pkg::IOD_OP_IO_WRITE,
         iod_pkg::IOD_OP_STORE: begin
            is_store = 1'b1;
         end
         iod_pkg::IOD_OP_SET_BIT,
         iod_pkg::IOD_OP_CLEAR_BIT: begin
            is_bit_op = 1'b1;
         end
         iod_pkg::IOD_OP_SKIP_SET,
         iod_pkg::IOD_OP_SKIP_CLEAR: begin
            is_skip = 1'b1;
         end
         default: begin
            is_read = 1'b0;
         end
      endcase
   end

   // hardware events routed onto the flag entries; others never set
   always_comb begin
      hw_set = '0;
      hw_set[iod_pkg::IOD_IDX_TIMER0_FLAGS]                          = {4'h0, evt_timer0};
      hw_set[iod_pkg::IOD_IDX_TIMER1_FLAGS]                          = {4'h0, evt_timer1};
      hw_set[iod_pkg::IOD_IDX_PIN_CHANGE]                            = {6'h00, evt_pin_change};
      hw_set[iod_pkg::IOD_IDX_EXT_INT_FLAG]                          = {7'h00, evt_ext_int};
      hw_set[iod_pkg::IOD_IDX_WATCHDOG][iod_pkg::IOD_WD_FLAG_BIT]    = evt_watchdog;
      hw_set[iod_pkg::IOD_IDX_WAKEUP][iod_pkg::IOD_WU_FLAG_BIT]      = evt_wakeup;
   end

   // one storage cell, read gate and write strobe per map entry
   for (genvar i = 0; i < N; i++) begin : g_reg
      iod_reg_cell #(
         .MASK (iod_pkg::IOD_MAP[i].mask),
         .W1C  (iod_pkg::IOD_MAP[i].w1c)
      ) u_cell (
         .mclk   (mclk),
         .rstn   (rstn),
         .wr     (wr_en[i]),
         .wdata  (wr_data),
         .hw_set (hw_set[i]),
         .value  (value[i])
      );
      // an unselected or reserved address contributes zero
      assign rd_part[i] = sel[i] ? value[i] : 8'h00;
      // a refused access never reaches a cell
      assign wr_en[i]   = acc_req && sel[i] && (is_store || is_bit_op);
   end

   // merge the read gates; pending view of every write-one-to-clear flag
   always_comb begin
      cur     = 8'h00;
      pend_or = 8'h00;
      for (int k = 0; k < N; k++) begin
         cur     = cur | rd_part[k];
         pend_or = pend_or | (value[k] & iod_pkg::IOD_MAP[k].w1c);
      end
   end

   // single-bit ops rewrite the full byte as read, so any set flag but the bit a clear-bit targets is
   // written back as one and clears; this is the documented side effect
   always_comb begin
      bit_mask = 8'h01 << acc_bit;
      wr_data  = acc_wdata;
      if (is_bit_op) begin
         if (acc_op == iod_pkg::IOD_OP_SET_BIT) begin
            wr_data = cur | bit_mask;
         end else begin
            wr_data = cur & ~bit_mask;
         end
      end
   end

   // bit under test for the skip instructions
   assign cur_bit = |(cur & bit_mask);

   // answer one cycle after the request; reads return the value before any write
   always_comb begin
      next_q         = q;
      next_q.valid   = acc_req;
      next_q.rdata   = 8'h00;
      next_q.skip    = 1'b0;
      next_q.hit     = 1'b0;
      next_q.refused = 1'b0;
      if (acc_req) begin
         next_q.hit     = hit;
         next_q.refused = refused;
         if (is_read || is_skip) begin
            next_q.rdata = cur;
         end
         if (is_skip && !refused) begin
            if (acc_op == iod_pkg::IOD_OP_SKIP_SET) begin
               next_q.skip = cur_bit;
            end else begin
               next_q.skip = !cur_bit;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q.valid   <= 1'b0;
         q.rdata   <= iod_pkg::IOD_RESET_VALUE;
         q.skip    <= 1'b0;
         q.hit     <= 1'b0;
         q.refused <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   // answer ports
   assign rsp_valid   = q.valid;
   assign rsp_rdata   = q.rdata;
   assign rsp_skip    = q.skip;
   assign rsp_hit     = q.hit;
   assign rsp_refused = q.refused;

   // register contents the rest of the chip consumes, straight from the cells
   assign status_flags  = value[iod_pkg::IOD_IDX_STATUS];
   assign stack_ptr     = {value[iod_pkg::IOD_IDX_STACK_HIGH], value[iod_pkg::IOD_IDX_STACK_LOW]};
   assign ext_int_mask  = value[iod_pkg::IOD_IDX_EXT_INT_MASK][0];
   // or of flop outputs only, so no path from the request pins
   assign flags_pending = |pend_or;

endmodule // iod_top

/* bench/iod_top_checker.sv */
`timescale 1ns/1ps

module iod_top_checker (
   input wire logic             mclk,
   input wire logic             rstn,
   input wire logic             acc_req,
   input wire iod_pkg::iod_op_t acc_op,
   input wire logic [7:0]       acc_addr,
   input wire logic [7:0]       acc_wdata,
   input wire logic [2:0]       acc_bit,
   input wire logic             evt_ext_int,
   input wire logic             rsp_valid,
   input wire logic [7:0]       rsp_rdata,
   input wire logic             rsp_skip,
   input wire logic             rsp_hit,
   input wire logic             rsp_refused,
   input wire logic [7:0]       status_flags,
   input wire logic             flags_pending
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // op classes, decoded once so the properties stay short
   logic bit_op;
   logic io_op;
   logic ls_op;
   assign bit_op = acc_req && acc_op inside {[3'h2:3'h5]};
   assign io_op  = acc_req && acc_op[2:1] == 2'b00;
   assign ls_op  = acc_req && acc_op[2:1] == 2'b11;

   a_rsp_one_cycle: assert property (acc_req |=> rsp_valid)
      else $error("no answer one cycle after a request");
   a_rsp_quiet_idle: assert property (!rsp_valid
      |-> !(rsp_hit || rsp_refused || rsp_skip))
      else $error("answer flags set with no answer pending");
   a_bit_op_refused: assert property (bit_op && acc_addr > 8'h1f
      |=> rsp_refused && !rsp_hit)
      else $error("bit op above bit window not refused");
   a_short_io_refused: assert property (io_op && acc_addr >= 8'h40 |=> rsp_refused)
      else $error("short io op beyond 64 locations not refused");
   a_ls_low_refused: assert property (ls_op && acc_addr < 8'h20 |=> rsp_refused)
      else $error("load or store below data offset not refused");
   a_ext_ls_hit: assert property (ls_op && acc_addr inside {[8'h60:8'h64]}
      |=> rsp_hit && !rsp_refused)
      else $error("extended area not reached by load or store");
   a_refused_zero: assert property (rsp_refused |-> !rsp_hit && rsp_rdata == 8'h00)
      else $error("refused access returned data or hit");
   a_status_store: assert property (ls_op && acc_op[0] && acc_addr == 8'h5f
      |=> status_flags == $past(acc_wdata))
      else $error("store to status register did not land");
   a_skip_bit_value: assert property (bit_op && acc_op == iod_pkg::IOD_OP_SKIP_SET
      && acc_addr <= 8'h1f |=> rsp_skip == rsp_rdata[$past(acc_bit)])
      else $error("skip decision differs from tested bit");
   a_flag_pending: assert property (evt_ext_int |=> flags_pending)
      else $error("raised flag not pending");

   c_bit_refused: cover property (bit_op && acc_addr > 8'h1f);
   c_ext_store: cover property (ls_op && acc_op[0] && acc_addr >= 8'h60);
   c_skip_taken: cover property (rsp_valid && rsp_skip);
endmodule // iod_top_checker

bind iod_top iod_top_checker iod_top_checker_i (.mclk, .rstn, .acc_req, .acc_op, .acc_addr,
   .acc_wdata, .acc_bit, .evt_ext_int, .rsp_valid, .rsp_rdata, .rsp_skip, .rsp_hit,
   .rsp_refused, .status_flags, .flags_pending);

/* bench/iod_core_model.sv */
`timescale 1ns/1ps

module iod_core_model (
   input  wire logic             mclk,
   output iod_pkg::iod_op_t      acc_op,
   output logic                  acc_req,
   output logic [7:0]            acc_addr,
   output logic [7:0]            acc_wdata,
   output logic [2:0]            acc_bit,
   input  wire logic             rsp_valid,
   input  wire logic [7:0]       rsp_rdata,
   input  wire logic             rsp_skip,
   input  wire logic             rsp_hit,
   input  wire logic             rsp_refused,
   output logic [7:0]            got_rdata,
   output logic [3:0]            got_flags
);
   // idle bus from time zero
   initial begin
      acc_req   = 1'b0;
      acc_op    = iod_pkg::IOD_OP_IO_READ;
      acc_addr  = 8'h00;
      acc_wdata = 8'h00;
      acc_bit   = 3'h0;
   end

   // one access: held over the taking edge, answer captured one cycle on
   // callers keep reserved bits zero and never write reserved places
   task automatic access(input iod_pkg::iod_op_t op, input logic [7:0] a, w,
                         input logic [2:0] b);
      @(negedge mclk);
      acc_req   = 1'b1;
      acc_op    = op;
      acc_addr  = a;
      acc_wdata = w;
      acc_bit   = b;
      @(negedge mclk);
      acc_req   = 1'b0;
      acc_wdata = ~w; // stale data must not be mistaken for live data
      got_rdata = rsp_rdata;
      got_flags = {rsp_valid, rsp_hit, rsp_refused, rsp_skip};
   endtask
endmodule // iod_core_model

/* bench/iod_top_tb.sv */
`timescale 1ns/1ps

module iod_top_tb;
   localparam iod_pkg::iod_op_t op_rd = iod_pkg::IOD_OP_IO_READ;
   localparam iod_pkg::iod_op_t op_wr = iod_pkg::IOD_OP_IO_WRITE;
   localparam iod_pkg::iod_op_t op_set = iod_pkg::IOD_OP_SET_BIT;
   localparam iod_pkg::iod_op_t op_clr = iod_pkg::IOD_OP_CLEAR_BIT;
   localparam iod_pkg::iod_op_t op_sks = iod_pkg::IOD_OP_SKIP_SET;
   localparam iod_pkg::iod_op_t op_skc = iod_pkg::IOD_OP_SKIP_CLEAR;
   localparam iod_pkg::iod_op_t op_load = iod_pkg::IOD_OP_LOAD;
   localparam iod_pkg::iod_op_t op_store = iod_pkg::IOD_OP_STORE;
   localparam logic [7:0] off = iod_pkg::IOD_DATA_OFFSET;

   logic             mclk;
   logic             rstn;
   logic [12:0]      ev;
   iod_pkg::iod_op_t acc_op;
   logic             acc_req, rsp_valid, rsp_skip, rsp_hit, rsp_refused, ext_int_mask;
   logic             flags_pending;
   logic [7:0]       acc_addr, acc_wdata, rsp_rdata, status_flags, got;
   logic [2:0]       acc_bit;
   logic [3:0]       f;
   logic [15:0]      stack_ptr;
   int               error_cnt;
   int               checked;

   iod_top iod_top_i (.mclk(mclk), .rstn(rstn), .acc_req(acc_req), .acc_op(acc_op),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_bit(acc_bit),
      .evt_timer0(ev[3:0]), .evt_timer1(ev[7:4]), .evt_pin_change(ev[9:8]),
      .evt_ext_int(ev[10]), .evt_watchdog(ev[11]), .evt_wakeup(ev[12]),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip),
      .rsp_hit(rsp_hit), .rsp_refused(rsp_refused), .status_flags(status_flags),
      .stack_ptr(stack_ptr), .ext_int_mask(ext_int_mask), .flags_pending(flags_pending));

   iod_core_model iod_core_model_i (.mclk(mclk), .acc_op(acc_op), .acc_req(acc_req),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_bit(acc_bit),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip),
      .rsp_hit(rsp_hit), .rsp_refused(rsp_refused), .got_rdata(got), .got_flags(f));

   // 50 MHz core clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic chk(input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // every access must be answered; f is {valid, hit, refused, skip}
   task automatic acc(input iod_pkg::iod_op_t op, input logic [7:0] a, w, input logic [2:0] b);
      iod_core_model_i.access(op, a, w, b);
      chk(16'(f[3]), 16'h1);
   endtask

   // one-cycle event pulse, launched off the sampling edge
   task automatic pulse(input logic [12:0] v);
      @(negedge mclk);
      ev = v;
      @(negedge mclk);
      ev = '0;
   endtask

   task automatic t_map;
      acc(op_rd, 8'h1e, 8'h00, 3'h0);
      chk(16'({got, f[2:1]}), 16'h0002);
      acc(op_wr, 8'h1e, 8'h5a, 3'h0);
      chk(16'(f[2:1]), 16'h2);
      acc(op_load, 8'h1e + off, 8'h00, 3'h0);
      chk(16'(got), 16'h5a);
      acc(op_rd, 8'h40, 8'h00, 3'h0);
      chk(16'(f[2:1]), 16'h1);
      acc(op_load, 8'h1f, 8'h00, 3'h0);
      chk(16'(f[2:1]), 16'h1);
      acc(op_store, 8'h3f + off, 8'hc3, 3'h0);
      chk(16'(status_flags), 16'hc3);
      acc(op_rd, 8'h3f, 8'h00, 3'h0);
      chk(16'(got), 16'hc3);
      acc(op_store, 8'h5d, 8'h34, 3'h0);
      acc(op_wr, 8'h3e, 8'h12, 3'h0);
      chk(stack_ptr, 16'h1234);
      acc(op_load, 8'h60, 8'h00, 3'h0);
      chk(16'(f[2:1]), 16'h2);
      acc(op_store, 8'h66, 8'h5c, 3'h0);
      acc(op_load, 8'h66, 8'h00, 3'h0);
      chk(16'(got), 16'h5c);
      acc(op_rd, 8'h1a, 8'h00, 3'h0);
      chk(16'({got, f[2:1]}), 16'h0000);
      acc(op_store, 8'h3d, 8'h01, 3'h0);
      chk(16'(ext_int_mask), 16'h1);
   endtask

   task automatic t_bits;
      acc(op_set, 8'h1e, 8'h00, 3'h0);
      acc(op_rd, 8'h1e, 8'h00, 3'h0);
      chk(16'(got), 16'h5b);
      acc(op_clr, 8'h1e, 8'h00, 3'h6);
      acc(op_rd, 8'h1e, 8'h00, 3'h0);
      chk(16'(got), 16'h1b);
      acc(op_sks, 8'h1e, 8'h00, 3'h3);
      chk(16'(f[0]), 16'h1);
      acc(op_skc, 8'h1e, 8'h00, 3'h2);
      chk(16'(f[0]), 16'h1);
      acc(op_set, 8'h20, 8'h00, 3'h0);
      chk(16'(f[2:1]), 16'h1);
      acc(op_rd, 8'h20, 8'h00, 3'h0);
      chk(16'(got), 16'h00);
      acc(op_sks, 8'h3f, 8'h00, 3'h0);
      chk(16'({got, f[1]}), 16'h0001);
   endtask

   task automatic t_flags;
      pulse(13'h0005);
      acc(op_rd, 8'h15, 8'h00, 3'h0);
      chk({got, 7'h0, flags_pending}, 16'h0501);
      acc(op_store, 8'h35, 8'h01, 3'h0);
      acc(op_rd, 8'h15, 8'h00, 3'h0);
      chk(16'(got), 16'h04);
      pulse(13'h0002);
      acc(op_set, 8'h15, 8'h00, 3'h1);
      acc(op_rd, 8'h15, 8'h00, 3'h0);
      chk({got, 7'h0, flags_pending}, 16'h0000);
      pulse(13'h0400);
      chk(16'(flags_pending), 16'h1);
      acc(op_store, 8'h3c, 8'h01, 3'h0);
      chk(16'(flags_pending), 16'h0);
   endtask

   // timer1, watchdog and wakeup flags: raised together, cleared one by one
   task automatic t_events;
      pulse(13'h18f0);
      acc(op_load, 8'h60, 8'h00, 3'h0);
      chk(16'(got), 16'h80);
      acc(op_store, 8'h60, 8'h80, 3'h0);
      acc(op_load, 8'h60, 8'h00, 3'h0);
      chk(16'(got), 16'h00);
      // clearing bit 0 writes the others back as one, so only bit 0 survives
      acc(op_clr, 8'h16, 8'h00, 3'h0);
      acc(op_rd, 8'h16, 8'h00, 3'h0);
      chk(16'(got), 16'h01);
      acc(op_store, 8'h36, 8'h01, 3'h0);
      chk(16'(flags_pending), 16'h1);
      acc(op_store, 8'h62, 8'h80, 3'h0);
      chk(16'(flags_pending), 16'h0);
   endtask

   task automatic finish_test;
      $display("error_cnt=%0d checked=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // reset, then the scenarios in turn
   initial begin
      error_cnt = 0;
      checked = 0;
      ev = '0;
      rstn = 1'b0;
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      t_map();
      t_bits();
      t_flags();
      t_events();
      finish_test();
   end

   // whole run is under a hundred cycles; this cuts a hang
   initial begin
      #100us;
      error_cnt++;
      finish_test();
   end
endmodule // iod_top_tb
